// ===== verilog/pll_cfg_pkg.sv
// Register map, field layout, reset values and timing for the clock path block
package pll_cfg_pkg;

  // Register addresses
  localparam logic [9:0] PLL_CTRL_OFS     = 10'h010;
  localparam logic [9:0] ABL_CTRL_OFS     = 10'h017;
  localparam logic [9:0] OSC_CAL_OFS      = 10'h018;
  localparam logic [9:0] OSC_DIV_OFS      = 10'h1E0;
  localparam logic [9:0] SRC_SEL_OFS      = 10'h1E1;
  localparam logic [9:0] UPDATE_OFS       = 10'h232;
  localparam logic [9:0] PUMP_CUR_OFS     = 10'h240;
  localparam logic [9:0] STATUS_OFS       = 10'h241;

  // Field positions
  localparam int PWR_LSB      = 0;
  localparam int PWR_MSB      = 1;
  localparam int CP_MODE_LSB  = 4;
  localparam int CP_MODE_MSB  = 6;
  localparam int PFD_POL_BIT  = 7;
  localparam int ABL_LSB      = 0;
  localparam int ABL_MSB      = 1;
  localparam int CAL_BIT      = 0;
  localparam int DIV_LSB      = 0;
  localparam int DIV_MSB      = 2;
  localparam int BYPASS_BIT   = 0;
  localparam int OSC_SEL_BIT  = 1;
  localparam int UPDATE_BIT   = 0;
  localparam int ICP_LSB      = 0;
  localparam int ICP_MSB      = 2;

  // Field encodings
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_DOWN     = 2'h1;
  localparam logic [2:0] CP_HIZ       = 3'h0;
  localparam logic [2:0] CP_PUMP_UP   = 3'h1;
  localparam logic [2:0] CP_PUMP_DOWN = 3'h2;
  localparam logic [2:0] CP_NORMAL    = 3'h3;
  localparam logic [2:0] DIV_BY4      = 3'h2;

  // Reset values
  localparam logic [7:0] PLL_CTRL_RST = 8'h01;
  localparam logic [7:0] ABL_CTRL_RST = 8'h00;
  localparam logic [7:0] OSC_CAL_RST  = 8'h00;
  localparam logic [7:0] OSC_DIV_RST  = 8'h02;
  localparam logic [7:0] SRC_SEL_RST  = 8'h00;
  localparam logic [7:0] PUMP_CUR_RST = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CAL_TIME_NS    = 10000;
  localparam int CAL_CYCLES_INT = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] CAL_CYCLES = CAL_CYCLES_INT[9:0];

endpackage

// ===== verilog/pll_clock_path_config.sv
// Clock path and PLL configuration: staged registers, source/divider path, PFD and charge pump control
`timescale 1ns/10ps
`default_nettype none

module pll_clock_path_config
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Register port
  input  wire logic [9:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Sampled clock sources and divider feedback
  input  wire logic       ext_clk_i,
  input  wire logic       osc_clk_i,
  input  wire logic       ref_div_i,
  input  wire logic       fb_div_i,
  // Clock path controls
  output logic            dist_clk_o,
  output logic            osc_select_o,
  output logic            divider_bypass_o,
  output logic            pll_powerdown_o,
  // Charge pump
  output logic            pump_up_o,
  output logic            pump_down_o,
  output logic            pump_hiz_o,
  output logic      [2:0] pump_current_setting_o,
  // Calibration
  output logic            cal_start_o,
  output logic            cal_busy_o
);

  // Divider code to ratio
  function automatic logic [2:0] div_ratio(input logic [2:0] code);
    unique case (code)
      3'h0:    div_ratio = 3'h2;
      3'h1:    div_ratio = 3'h3;
      3'h2:    div_ratio = 3'h4;
      3'h3:    div_ratio = 3'h5;
      3'h4:    div_ratio = 3'h6;
      default: div_ratio = 3'h2;
    endcase
  endfunction

  logic [7:0] pll_ctrl_ff, abl_ctrl_ff, osc_cal_ff, osc_div_ff, src_sel_ff, pump_cur_ff;
  logic [7:0] act_pll_ff, act_abl_ff, act_cal_ff, act_div_ff, act_src_ff, act_cur_ff;
  logic       upd_ff;
  logic [3:0] sync1_ff, sync2_ff, prev_ff;
  logic [2:0] div_cnt_ff;
  logic       up_ff, dn_ff;
  logic [1:0] abl_cnt_ff;
  logic [9:0] cal_cnt_ff;

  // Staging registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pll_ctrl_ff <= PLL_CTRL_RST;
      abl_ctrl_ff <= ABL_CTRL_RST;
      osc_cal_ff  <= OSC_CAL_RST;
      osc_div_ff  <= OSC_DIV_RST;
      src_sel_ff  <= SRC_SEL_RST;
      pump_cur_ff <= PUMP_CUR_RST;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        PLL_CTRL_OFS: pll_ctrl_ff <= wdata_i;
        ABL_CTRL_OFS: abl_ctrl_ff <= wdata_i;
        OSC_CAL_OFS:  osc_cal_ff  <= wdata_i;
        OSC_DIV_OFS:  osc_div_ff  <= wdata_i;
        SRC_SEL_OFS:  src_sel_ff  <= wdata_i;
        PUMP_CUR_OFS: pump_cur_ff <= wdata_i;
        default:      ;
      endcase
    end
  end

  // Update request; a new request wins over the self-clear
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      upd_ff <= 1'b0;
    else if (wr_i && addr_i == UPDATE_OFS && wdata_i[UPDATE_BIT])
      upd_ff <= 1'b1;
    else
      upd_ff <= 1'b0;
  end

  // Active copies load together
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      act_pll_ff <= PLL_CTRL_RST;
      act_abl_ff <= ABL_CTRL_RST;
      act_cal_ff <= OSC_CAL_RST;
      act_div_ff <= OSC_DIV_RST;
      act_src_ff <= SRC_SEL_RST;
      act_cur_ff <= PUMP_CUR_RST;
    end
    else if (upd_ff)
    begin
      act_pll_ff <= pll_ctrl_ff;
      act_abl_ff <= abl_ctrl_ff;
      act_cal_ff <= osc_cal_ff;
      act_div_ff <= osc_div_ff;
      act_src_ff <= src_sel_ff;
      act_cur_ff <= pump_cur_ff;
    end
  end

  // Read port
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      unique case (addr_i)
        PLL_CTRL_OFS: rdata_o <= pll_ctrl_ff;
        ABL_CTRL_OFS: rdata_o <= abl_ctrl_ff;
        OSC_CAL_OFS:  rdata_o <= osc_cal_ff;
        OSC_DIV_OFS:  rdata_o <= osc_div_ff;
        SRC_SEL_OFS:  rdata_o <= src_sel_ff;
        UPDATE_OFS:   rdata_o <= {7'h00, upd_ff};
        PUMP_CUR_OFS: rdata_o <= pump_cur_ff;
        STATUS_OFS:   rdata_o <= {4'h0, up_ff, dn_ff, cal_busy_o, pll_powerdown_o};
        default:      rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  // Input synchronisers: {fb, ref, osc, ext}
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff  <= 4'h0;
    end
    else
    begin
      sync1_ff <= {fb_div_i, ref_div_i, osc_clk_i, ext_clk_i};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  logic       osc_sel, src_lvl, src_rise, ref_rise, fb_rise, pwr_on;
  logic [2:0] ratio;
  assign osc_sel  = act_src_ff[OSC_SEL_BIT];
  assign src_lvl  = osc_sel ? sync2_ff[1] : sync2_ff[0];
  assign src_rise = osc_sel ? (sync2_ff[1] & ~prev_ff[1]) : (sync2_ff[0] & ~prev_ff[0]);
  assign ref_rise = sync2_ff[2] & ~prev_ff[2];
  assign fb_rise  = sync2_ff[3] & ~prev_ff[3];
  assign ratio    = div_ratio(act_div_ff[DIV_MSB:DIV_LSB]);
  assign pwr_on   = act_pll_ff[PWR_MSB:PWR_LSB] == PWR_NORMAL;

  // Oscillator divider, counts source edges
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_cnt_ff <= 3'h0;
    else if (src_rise)
      div_cnt_ff <= (div_cnt_ff >= ratio - 3'h1) ? 3'h0 : div_cnt_ff + 3'h1;
  end

  // Distribution clock and path outputs
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dist_clk_o       <= 1'b0;
      osc_select_o     <= 1'b0;
      divider_bypass_o <= 1'b0;
      pll_powerdown_o  <= 1'b1;
      pump_current_setting_o <= 3'h0;
    end
    else
    begin
      if (act_src_ff[BYPASS_BIT])
        dist_clk_o <= src_lvl;
      else
        dist_clk_o <= div_cnt_ff < (ratio >> 1);
      osc_select_o     <= osc_sel;
      divider_bypass_o <= act_src_ff[BYPASS_BIT];
      pll_powerdown_o  <= ~pwr_on;
      pump_current_setting_o <= act_cur_ff[ICP_MSB:ICP_LSB];
    end
  end

  // Phase detector with antibacklash overlap
  logic [1:0] abl_width;
  assign abl_width = act_abl_ff[ABL_MSB:ABL_LSB];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      up_ff      <= 1'b0;
      dn_ff      <= 1'b0;
      abl_cnt_ff <= 2'h0;
    end
    else if (!pwr_on || (up_ff && dn_ff && abl_cnt_ff == abl_width))
    begin
      up_ff      <= 1'b0;
      dn_ff      <= 1'b0;
      abl_cnt_ff <= 2'h0;
    end
    else if (up_ff && dn_ff)
      abl_cnt_ff <= abl_cnt_ff + 2'h1;
    else
    begin
      if (ref_rise)
        up_ff <= 1'b1;
      if (fb_rise)
        dn_ff <= 1'b1;
    end
  end

  // Charge pump drive; unused mode codes and power-down leave it high impedance
  logic       cp_up, cp_dn, swap, pump_on;
  logic [2:0] cp_mode;
  assign swap    = act_pll_ff[PFD_POL_BIT] & ~osc_sel;
  assign cp_up   = swap ? dn_ff : up_ff;
  assign cp_dn   = swap ? up_ff : dn_ff;
  assign cp_mode = act_pll_ff[CP_MODE_MSB:CP_MODE_LSB];
  assign pump_on = pwr_on && (cp_mode == CP_NORMAL || cp_mode == CP_PUMP_UP || cp_mode == CP_PUMP_DOWN);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pump_up_o   <= 1'b0;
      pump_down_o <= 1'b0;
      pump_hiz_o  <= 1'b1;
    end
    else
    begin
      pump_up_o   <= pump_on && (cp_mode == CP_PUMP_UP || (cp_mode == CP_NORMAL && cp_up));
      pump_down_o <= pump_on && (cp_mode == CP_PUMP_DOWN || (cp_mode == CP_NORMAL && cp_dn));
      pump_hiz_o  <= !pump_on;
    end
  end

  // Calibration starts on a 0 to 1 change of the active bit
  logic cal_go;
  assign cal_go = upd_ff & osc_cal_ff[CAL_BIT] & ~act_cal_ff[CAL_BIT];

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cal_start_o <= 1'b0;
      cal_busy_o  <= 1'b0;
      cal_cnt_ff  <= 10'h000;
    end
    else
    begin
      cal_start_o <= cal_go;
      if (cal_go)
      begin
        cal_busy_o <= 1'b1;
        cal_cnt_ff <= CAL_CYCLES;
      end
      else if (cal_busy_o)
      begin
        cal_cnt_ff <= cal_cnt_ff - 10'h001;
        if (cal_cnt_ff == 10'h001)
          cal_busy_o <= 1'b0;
      end
    end
  end

  // Checks
  AST_UPDATE_SELF_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    upd_ff && !(wr_i && addr_i == UPDATE_OFS) |=> !upd_ff)
    else $error("update bit did not clear");
  AST_UPDATE_COPIES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    upd_ff |=> act_src_ff == $past(src_sel_ff) && act_pll_ff == $past(pll_ctrl_ff))
    else $error("update did not copy staged values");
  AST_NO_UPDATE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !upd_ff |=> $stable(act_src_ff) && $stable(act_div_ff))
    else $error("active value changed without update");
  AST_CAL_START: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cal_go |=> cal_start_o && cal_busy_o)
    else $error("calibration did not start");
  AST_CAL_NO_RESTART: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    upd_ff && act_cal_ff[CAL_BIT] |=> !cal_start_o)
    else $error("calibration restarted without clear");
  AST_POWERDOWN_PUMP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    act_pll_ff[PWR_MSB:PWR_LSB] == PWR_DOWN |=> pll_powerdown_o && pump_hiz_o && !pump_up_o)
    else $error("pump active in power-down");
  AST_BYPASS_PATH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    act_src_ff[BYPASS_BIT] |=> dist_clk_o == $past(src_lvl))
    else $error("bypass path wrong");
  AST_ABL_OVERLAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pwr_on && up_ff && dn_ff && abl_width == 2'h1 && abl_cnt_ff == 2'h0 |=> up_ff && dn_ff ##1 !up_ff && !dn_ff)
    else $error("antibacklash width wrong");
  AST_POLARITY_INTERNAL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    osc_sel |-> cp_up == up_ff)
    else $error("polarity applied with internal oscillator");
  AST_PUMP_UP_TEST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pwr_on && act_pll_ff[CP_MODE_MSB:CP_MODE_LSB] == CP_PUMP_UP && !upd_ff |=> pump_up_o && !pump_down_o)
    else $error("constant pump up not driven");

endmodule // pll_clock_path_config

`default_nettype wire

// ===== tb/tb.sv
// Self-checking testbench for the clock path configuration block
`timescale 1ns/10ps
`default_nettype none

module tb import pll_cfg_pkg::*;;
  logic       clk_i     = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [9:0] addr_i    = 10'h000;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       ext_clk_i = 1'b0;
  logic       osc_clk_i = 1'b0;
  logic       ref_div_i = 1'b0;
  logic       fb_div_i  = 1'b0;
  logic       ext_run   = 1'b0;
  logic       osc_run   = 1'b0;
  logic       dist_q    = 1'b0;
  logic [7:0] rdata_o;
  logic       dist_clk_o, osc_select_o, divider_bypass_o, pll_powerdown_o;
  logic       pump_up_o, pump_down_o, pump_hiz_o, cal_start_o, cal_busy_o;
  logic [2:0] pump_current_setting_o;
  int         mismatches = 0;
  int         n_compared = 0;
  int         edges      = 0;
  int         n;
  logic [9:0] ra [7] = '{PLL_CTRL_OFS, ABL_CTRL_OFS, OSC_CAL_OFS, OSC_DIV_OFS, SRC_SEL_OFS, PUMP_CUR_OFS, 10'h3FF};
  logic [7:0] rv [7] = '{PLL_CTRL_RST, ABL_CTRL_RST, OSC_CAL_RST, OSC_DIV_RST, SRC_SEL_RST, PUMP_CUR_RST, 8'h00};
  logic [2:0] cpm [3] = '{CP_HIZ, CP_PUMP_UP, CP_PUMP_DOWN};
  logic [2:0] cpe [3] = '{3'h4, 3'h2, 3'h1};

  always #12.5 clk_i = ~clk_i;

  // Source clocks toggle once per cycle while enabled; count distribution edges
  always @(posedge clk_i)
  begin
    ext_clk_i <= ext_run ? ~ext_clk_i : 1'b0;
    osc_clk_i <= osc_run ? ~osc_clk_i : 1'b0;
    dist_q    <= dist_clk_o;
    if (dist_clk_o && !dist_q)
      edges <= edges + 1;
  end

  pll_clock_path_config i_dut (
    .clk_i                  (clk_i),
    .rst_b_i                (rst_b_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .ext_clk_i              (ext_clk_i),
    .osc_clk_i              (osc_clk_i),
    .ref_div_i              (ref_div_i),
    .fb_div_i               (fb_div_i),
    .dist_clk_o             (dist_clk_o),
    .osc_select_o           (osc_select_o),
    .divider_bypass_o       (divider_bypass_o),
    .pll_powerdown_o        (pll_powerdown_o),
    .pump_up_o              (pump_up_o),
    .pump_down_o            (pump_down_o),
    .pump_hiz_o             (pump_hiz_o),
    .pump_current_setting_o (pump_current_setting_o),
    .cal_start_o            (cal_start_o),
    .cal_busy_o             (cal_busy_o)
  );

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp, what);
  endtask

  // Write, then commit with the update command and let outputs settle
  task automatic cfg(input logic [9:0] a, input logic [7:0] d);
    wr(a, d);
    wr(UPDATE_OFS, 8'h01);
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic meas(input int exp, input string what);
    int e0;
    repeat (20) @(posedge clk_i);
    e0 = edges;
    repeat (240) @(posedge clk_i);
    #1;
    chk({7'h00, (edges - e0 >= exp - 1) && (edges - e0 <= exp + 1)}, 8'h01, what);
  endtask

  task automatic cal_try(input logic exp);
    logic seen;
    seen = 1'b0;
    wr(UPDATE_OFS, 8'h01);
    repeat (6)
    begin
      @(posedge clk_i);
      #1;
      if (cal_start_o === 1'b1)
        seen = 1'b1;
    end
    chk({7'h00, seen}, {7'h00, exp}, "calibration start");
  endtask

  // Reference edge alone, then feedback edge; count overlap cycles until both clear
  task automatic pfd(input logic eu, input logic ed, input logic [7:0] ov);
    logic       su, sd;
    logic [7:0] nb;
    su = 1'b0;
    sd = 1'b0;
    nb = 8'h00;
    @(posedge clk_i);
    ref_div_i <= 1'b1;
    repeat (8)
    begin
      @(posedge clk_i);
      #1;
      su = su | pump_up_o;
      sd = sd | pump_down_o;
    end
    chk({6'h00, su, sd}, {6'h00, eu, ed}, "pfd direction");
    @(posedge clk_i);
    fb_div_i  <= 1'b1;
    ref_div_i <= 1'b0;
    repeat (12)
    begin
      @(posedge clk_i);
      #1;
      if (pump_up_o === 1'b1 && pump_down_o === 1'b1)
        nb = nb + 8'h01;
    end
    chk({6'h00, pump_up_o, pump_down_o}, 8'h00, "pfd clear");
    chk(nb, ov, "antibacklash overlap");
    @(posedge clk_i);
    fb_div_i  <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk({3'h0, pll_powerdown_o, osc_select_o, divider_bypass_o, pump_hiz_o, cal_busy_o}, 8'h12, "reset outputs");
    for (int i = 0; i < 7; i++)
      rd(ra[i], rv[i], "reset value");
    rd(STATUS_OFS, 8'h01, "status at reset");
    $display("test reset done");
    wr(SRC_SEL_OFS, 8'h03);
    repeat (3) @(posedge clk_i);
    #1;
    chk({6'h00, osc_select_o, divider_bypass_o}, 8'h00, "staged not active");
    rd(SRC_SEL_OFS, 8'h03, "staged readback");
    cfg(UPDATE_OFS, 8'h01);
    chk({6'h00, osc_select_o, divider_bypass_o}, 8'h03, "update applied");
    rd(UPDATE_OFS, 8'h00, "update self clear");
    $display("test staging done");
    ext_run <= 1'b1;
    meas(0, "oscillator selected, stopped");
    osc_run <= 1'b1;
    meas(120, "oscillator bypass");
    osc_run <= 1'b0;
    cfg(SRC_SEL_OFS, 8'h00);
    for (int c = 0; c < 5; c++)
    begin
      cfg(OSC_DIV_OFS, 8'(c));
      meas(120 / (c + 2), "divider ratio");
    end
    cfg(SRC_SEL_OFS, 8'h01);
    meas(120, "external bypass");
    $display("test clock path done");
    cfg(PLL_CTRL_OFS, 8'h30);
    chk({7'h00, pll_powerdown_o}, 8'h00, "pll normal");
    cfg(PLL_CTRL_OFS, 8'h31);
    chk({7'h00, pll_powerdown_o}, 8'h01, "pll power down");
    for (int m = 0; m < 3; m++)
    begin
      cfg(PLL_CTRL_OFS, {1'b0, cpm[m], 4'h0});
      chk({5'h00, pump_hiz_o, pump_up_o, pump_down_o}, {5'h00, cpe[m]}, "pump mode");
    end
    cfg(PLL_CTRL_OFS, 8'h30);
    pfd(1'b1, 1'b0, 8'h01);
    cfg(ABL_CTRL_OFS, 8'h01);
    cfg(PLL_CTRL_OFS, 8'hB0);
    pfd(1'b0, 1'b1, 8'h02);
    cfg(SRC_SEL_OFS, 8'h02);
    cfg(ABL_CTRL_OFS, 8'h03);
    pfd(1'b1, 1'b0, 8'h04);
    $display("test phase detector done");
    wr(PUMP_CUR_OFS, 8'h07);
    #1;
    chk({5'h00, pump_current_setting_o}, 8'h00, "current staged");
    cfg(UPDATE_OFS, 8'h01);
    chk({5'h00, pump_current_setting_o}, 8'h07, "current active");
    rd(PUMP_CUR_OFS, 8'h07, "current readback");
    osc_run <= 1'b1;
    wr(OSC_CAL_OFS, 8'h01);
    cal_try(1'b1);
    chk({7'h00, cal_busy_o}, 8'h01, "calibration busy");
    rd(STATUS_OFS, 8'h02, "status busy");
    n = 0;
    while (cal_busy_o === 1'b1 && n < 1000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 1000)
      mismatches++;
    else
    begin
      chk({7'h00, n >= 380 && n <= 400}, 8'h01, "calibration length");
      cal_try(1'b0);
      cfg(OSC_CAL_OFS, 8'h00);
      wr(OSC_CAL_OFS, 8'h01);
      cal_try(1'b1);
      rd(10'h3FF, 8'h00, "unmapped read");
      $display("test calibration done");
    end
    final_report();
  end
endmodule // tb

`default_nettype wire
